// ### rtl/perf_counters.sv
// Receive framer performance monitor: line, framing and second counters.
// Assumes event inputs are one-cycle pulses from logic on clock_i.
//
// Contract
// - AMI: count violations and each run of sixteen zeros, 16-bit counter.
// - B8ZS: count violations, code violations and each zero 8-bit span.
// - HDB3: count violations, code violations and each zero 4-bit span.
// - Superframe: select bit 1 counts both framing bits, 0 only terminal.
// - DDS counts terminal, signalling, slot 24 errors; ESF its framing bits.
// - E1: select 0 counts alignment and bit 2 errors, 1 alignment only.
// - ESF or E1 CRC: 16-bit counter of checksum errors.
// - Flag excessive checksum errors: 320 ESF or 915 E1 per second.
// - E1 CRC-4: 16-bit counter of received E bits at zero.
// - Count errored seconds from the enabled conditions, 16-bit.
// - Default errored condition chosen by framing mode and terminal side.
// - T1 bursty second: above one and below 8 or 320 events.
// - E1 bursty second: above one and below 16 or 915 events.
// - Severe second: 8 framing or 320 checksum errors on T1.
// - E1 severe second: 16 framing or 915 selected events.
// - Threshold registers replace hardwired limits when nonzero.
// - Count each second spent unavailable, 16-bit.
// - Enter unavailable after ten consecutive severe seconds.
// - Leave unavailable after ten consecutive seconds not severe.
// - No errored or severe second counting while unavailable; bursty seconds still count.
`timescale 1ns/10ps
module perf_counters
  import perf_mon_pkg::*;
#(
  parameter int SECOND_LEN = SECOND_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic bit_valid_i,
  input wire logic one_pulse_i,
  input wire logic line_code_violation_i,
  input wire logic code_viol_i,
  input wire logic terminal_framing_bit_err_i,
  input wire logic signalling_framing_bit_err_i,
  input wire logic ts24_align_err_i,
  input wire logic extended_superframe_framing_bit_err_i,
  input wire logic fas_err_i,
  input wire logic nfas_err_i,
  input wire logic crc_err_i,
  input wire logic ebit_zero_i,
  input wire logic sa6_stb_i,
  input wire logic [3:0] sa6_code_i,
  output logic unavail_o,
  output logic excess_crc_o,
  output logic second_tick_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    line_code_t lc;
    frame_mode_t fm;
    e1_side_t sd;
    logic fcs;
    logic [15:0] es_thr;
    logic [15:0] bes_thr;
    logic [15:0] ses_thr;
    logic [7:0] en;
    logic [4:0] zrun;
    logic [SEC_W-1:0] sel_sec;
    logic [SEC_W-1:0] crc_sec;
    logic [15:0] line_code_violation;
    logic [7:0] align;
    logic [15:0] crc;
    logic [15:0] ebit;
    logic [15:0] es;
    logic [15:0] bes;
    logic [15:0] ses;
    logic [15:0] uas;
    logic [3:0] run;
    logic unavail;
    logic excrc;
    logic tick;
    logic [DATA_W-1:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic tick;
  logic zero_evt;
  logic bpv_evt;
  logic align_evt;
  logic crc_evt;
  logic ebit_evt;
  logic sa6_nt_evt;
  logic sa6_ntr_evt;
  logic [2:0] sel_inc;
  logic [SEC_W-1:0] sel_tot;
  logic [SEC_W-1:0] crc_tot;
  logic [SEC_W-1:0] es_lim;
  logic [SEC_W-1:0] bes_lim;
  logic [SEC_W-1:0] ses_lim;
  logic [SEC_W-1:0] exc_lim;
  logic es_hit;
  logic bes_hit;
  logic ses_hit;
  logic t1_mode;

  second_timer #(
    .CYCLES(SECOND_LEN)
  ) u_timer (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .tick_o(tick)
  );

  function automatic logic [15:0] bump16(input logic [15:0] v, input logic clr,
                                         input logic inc);
    logic [15:0] b;
    b = clr ? 16'h0000 : v;
    bump16 = (inc && b != 16'hFFFF) ? b + 16'h0001 : b;
  endfunction

  function automatic logic [SEC_W-1:0] add_sat(input logic [SEC_W-1:0] v,
                                               input logic [2:0] inc);
    logic [SEC_W:0] s;
    s = {1'b0, v} + {{(SEC_W - 2){1'b0}}, inc};
    add_sat = s[SEC_W] ? '1 : s[SEC_W-1:0];
  endfunction

  function automatic logic [SEC_W-1:0] pick(input logic [15:0] r,
                                            input logic [SEC_W-1:0] d);
    pick = (r == 16'h0000) ? d : ((r[15:SEC_W] != '0) ? '1 : r[SEC_W-1:0]);
  endfunction

  // ----------------------------------------------------------------
  // Event classification
  // ----------------------------------------------------------------
  always_comb begin
    t1_mode = (st_r.fm != FM_E1) && (st_r.fm != FM_E1_CRC);
    zero_evt = 1'b0;
    if (bit_valid_i && !one_pulse_i) begin
      if (st_r.lc == LC_AMI) begin
        zero_evt = (st_r.zrun == AMI_ZERO_RUN - 5'h01);
      end else if (st_r.lc == LC_B8ZS) begin
        zero_evt = (st_r.zrun == B8ZS_ZERO_SPAN - 5'h01);
      end else begin
        zero_evt = (st_r.zrun == HDB3_ZERO_SPAN - 5'h01);
      end
    end
    bpv_evt = line_code_violation_i || zero_evt
      || (code_viol_i && st_r.lc != LC_AMI);
    case (st_r.fm)
      FM_SF_D4, FM_SF_SC: begin
        align_evt = terminal_framing_bit_err_i
          || (st_r.fcs && signalling_framing_bit_err_i);
      end
      FM_SF_DDS: begin
        align_evt = terminal_framing_bit_err_i || signalling_framing_bit_err_i
          || ts24_align_err_i;
      end
      FM_ESF: begin
        align_evt = extended_superframe_framing_bit_err_i;
      end
      default: begin
        align_evt = fas_err_i || (!st_r.fcs && nfas_err_i);
      end
    endcase
    crc_evt = crc_err_i && (st_r.fm == FM_ESF || st_r.fm == FM_E1_CRC);
    ebit_evt = ebit_zero_i && st_r.fm == FM_E1_CRC;
    sa6_nt_evt = sa6_stb_i && sa6_code_i[3:1] == 3'h1 && st_r.fm == FM_E1_CRC;
    sa6_ntr_evt = sa6_stb_i && sa6_code_i[3:2] == 2'h0 && sa6_code_i[0]
      && st_r.fm == FM_E1_CRC;
  end

  // ----------------------------------------------------------------
  // Per-second selection and limits
  // ----------------------------------------------------------------
  always_comb begin
    if (st_r.en[EN_OVR_BIT]) begin
      sel_inc = 3'(st_r.en[EN_ALIGN_BIT] && align_evt) + 3'(st_r.en[EN_CRC_BIT] && crc_evt)
        + 3'(st_r.en[EN_EBIT_BIT] && ebit_evt) + 3'(st_r.en[EN_SA6_NT_BIT] && sa6_nt_evt)
        + 3'(st_r.en[EN_SA6_NTR_BIT] && sa6_ntr_evt);
    end else if (st_r.fm == FM_ESF) begin
      sel_inc = 3'(crc_evt);
    end else if (st_r.fm != FM_E1_CRC) begin
      sel_inc = 3'(align_evt);
    end else begin
      case (st_r.sd)
        SD_LT: sel_inc = 3'(crc_evt);
        SD_LT_REMOTE: sel_inc = 3'(ebit_evt);
        SD_NT: sel_inc = 3'(sa6_nt_evt);
        default: sel_inc = 3'(sa6_ntr_evt);
      endcase
    end
    sel_tot = add_sat(st_r.sel_sec, sel_inc);
    crc_tot = add_sat(st_r.crc_sec, 3'(crc_evt));
    if (st_r.fm == FM_ESF) begin
      ses_lim = EXC_CRC_ESF;
      exc_lim = EXC_CRC_ESF;
    end else if (st_r.fm == FM_E1_CRC) begin
      ses_lim = EXC_CRC_E1;
      exc_lim = EXC_CRC_E1;
    end else begin
      ses_lim = t1_mode ? SES_T1_SF : SES_E1_PLAIN;
      exc_lim = '1;
    end
    ses_lim = pick(st_r.ses_thr, ses_lim);
    es_lim = pick(st_r.es_thr, ES_DEFAULT);
    bes_lim = pick(st_r.bes_thr, BES_DEFAULT);
    es_hit = sel_tot >= es_lim;
    ses_hit = sel_tot >= ses_lim;
    bes_hit = sel_tot >= bes_lim && !ses_hit;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic clr;
    clr = 1'b0;
    st_nxt = st_r;
    st_nxt.tick = tick;
    st_nxt.rdata = '0;
    if (wr_i) begin
      if (addr_i == OFS_MODE) begin
        st_nxt.lc = line_code_t'(wdata_i[MODE_LC_LSB +: 2]);
        st_nxt.fm = frame_mode_t'(wdata_i[MODE_FM_LSB +: 3]);
        st_nxt.sd = e1_side_t'(wdata_i[MODE_SD_LSB +: 2]);
      end else if (addr_i == OFS_FCS) begin
        st_nxt.fcs = wdata_i[FCS_BIT];
      end else if (addr_i == OFS_ES_THR) begin
        st_nxt.es_thr = wdata_i;
      end else if (addr_i == OFS_BES_THR) begin
        st_nxt.bes_thr = wdata_i;
      end else if (addr_i == OFS_SES_THR) begin
        st_nxt.ses_thr = wdata_i;
      end else if (addr_i == OFS_EVT_EN) begin
        st_nxt.en = wdata_i[7:0];
      end
    end
    if (bit_valid_i) begin
      if (one_pulse_i || (zero_evt && st_r.lc != LC_AMI)) begin
        st_nxt.zrun = 5'h00;
      end else if (st_r.zrun != AMI_ZERO_RUN) begin
        st_nxt.zrun = st_r.zrun + 5'h01;
      end
    end
    clr = wr_i && addr_i == OFS_BPV_CNT;
    st_nxt.line_code_violation = bump16(st_r.line_code_violation, clr, bpv_evt);
    clr = wr_i && addr_i == OFS_ALIGN_CNT;
    st_nxt.align = clr ? 8'h00 : st_r.align;
    if (align_evt && st_nxt.align != 8'hFF) begin
      st_nxt.align = st_nxt.align + 8'h01;
    end
    clr = wr_i && addr_i == OFS_CRC_CNT;
    st_nxt.crc = bump16(st_r.crc, clr, crc_evt);
    clr = wr_i && addr_i == OFS_EBIT_CNT;
    st_nxt.ebit = bump16(st_r.ebit, clr, ebit_evt);
    st_nxt.sel_sec = tick ? '0 : sel_tot;
    st_nxt.crc_sec = tick ? '0 : crc_tot;
    clr = wr_i && addr_i == OFS_ES_CNT;
    st_nxt.es = bump16(st_r.es, clr, tick && es_hit && !st_r.unavail);
    clr = wr_i && addr_i == OFS_BES_CNT;
    st_nxt.bes = bump16(st_r.bes, clr, tick && bes_hit);
    clr = wr_i && addr_i == OFS_SES_CNT;
    st_nxt.ses = bump16(st_r.ses, clr, tick && ses_hit && !st_r.unavail);
    clr = wr_i && addr_i == OFS_UAS_CNT;
    st_nxt.uas = bump16(st_r.uas, clr, tick && st_r.unavail);
    if (tick) begin
      st_nxt.excrc = crc_tot >= exc_lim;
      if (ses_hit != st_r.unavail) begin
        st_nxt.run = st_r.run + 4'h1;
        if (st_r.run == UAS_RUN - 4'h1) begin
          st_nxt.unavail = !st_r.unavail;
          st_nxt.run = 4'h0;
        end
      end else begin
        st_nxt.run = 4'h0;
      end
    end
    if (rd_i) begin
      if (addr_i == OFS_MODE) begin
        st_nxt.rdata = 16'({st_r.sd, st_r.fm, st_r.lc});
      end else if (addr_i == OFS_FCS) begin
        st_nxt.rdata = 16'({st_r.fcs, 2'h0});
      end else if (addr_i == OFS_ES_THR) begin
        st_nxt.rdata = st_r.es_thr;
      end else if (addr_i == OFS_BES_THR) begin
        st_nxt.rdata = st_r.bes_thr;
      end else if (addr_i == OFS_SES_THR) begin
        st_nxt.rdata = st_r.ses_thr;
      end else if (addr_i == OFS_EVT_EN) begin
        st_nxt.rdata = {8'h00, st_r.en};
      end else if (addr_i == OFS_STATUS) begin
        st_nxt.rdata = {14'h0000, st_r.excrc, st_r.unavail};
      end else if (addr_i == OFS_BPV_CNT) begin
        st_nxt.rdata = st_r.line_code_violation;
      end else if (addr_i == OFS_ALIGN_CNT) begin
        st_nxt.rdata = {8'h00, st_r.align};
      end else if (addr_i == OFS_CRC_CNT) begin
        st_nxt.rdata = st_r.crc;
      end else if (addr_i == OFS_EBIT_CNT) begin
        st_nxt.rdata = st_r.ebit;
      end else if (addr_i == OFS_ES_CNT) begin
        st_nxt.rdata = st_r.es;
      end else if (addr_i == OFS_BES_CNT) begin
        st_nxt.rdata = st_r.bes;
      end else if (addr_i == OFS_SES_CNT) begin
        st_nxt.rdata = st_r.ses;
      end else if (addr_i == OFS_UAS_CNT) begin
        st_nxt.rdata = st_r.uas;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '{lc: LC_AMI, fm: FM_SF_D4, sd: SD_LT, es_thr: THR_RESET,
                bes_thr: THR_RESET, ses_thr: THR_RESET, en: EVT_EN_RESET, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign unavail_o = st_r.unavail;
  assign excess_crc_o = st_r.excrc;
  assign second_tick_o = st_r.tick;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_tenth_ses;
    tick && ses_hit && !st_r.unavail && st_r.run == 4'h9;
  endsequence

  sequence s_tenth_clean;
    tick && !ses_hit && st_r.unavail && st_r.run == 4'h9;
  endsequence

  a_ami_zero_run: assert property (
    st_r.lc == LC_AMI && bit_valid_i && !one_pulse_i && st_r.zrun == 5'h0F
      && !wr_i && st_r.line_code_violation != 16'hFFFF |=> st_r.line_code_violation == $past(st_r.line_code_violation) + 16'h0001)
    else $error("zero run did not count");

  a_sf_sig_masked: assert property (
    (st_r.fm == FM_SF_D4 || st_r.fm == FM_SF_SC) && !st_r.fcs && signalling_framing_bit_err_i
      && !terminal_framing_bit_err_i && !wr_i |=> $stable(st_r.align))
    else $error("signalling bit counted while masked");

  a_e1_nfas_masked: assert property (
    st_r.fm == FM_E1 && st_r.fcs && nfas_err_i && !fas_err_i && !wr_i
      |=> $stable(st_r.align))
    else $error("bit 2 error counted while masked");

  a_crc_counts: assert property (
    st_r.fm == FM_ESF && crc_err_i && !wr_i && st_r.crc != 16'hFFFF
      |=> st_r.crc == $past(st_r.crc) + 16'h0001)
    else $error("checksum error lost");

  a_excess_crc: assert property (
    tick && st_r.fm == FM_ESF && crc_tot >= 14'h0140 |=> excess_crc_o ##1 excess_crc_o)
    else $error("excessive checksum flag missing");

  a_ses_default: assert property (
    tick && st_r.fm == FM_ESF && st_r.ses_thr == 16'h0000 && sel_tot == 14'h0140
      && !st_r.unavail && !wr_i && st_r.ses != 16'hFFFF
      |=> st_r.ses == $past(st_r.ses) + 16'h0001)
    else $error("severe second not counted");

  a_uas_counts: assert property (
    tick && st_r.unavail && !wr_i && st_r.uas != 16'hFFFF
      |=> st_r.uas == $past(st_r.uas) + 16'h0001)
    else $error("unavailable second not counted");

  a_unavail_entry: assert property (
    s_tenth_ses |=> unavail_o ##1 unavail_o)
    else $error("unavailable state not entered");

  a_unavail_exit: assert property (
    s_tenth_clean |=> !unavail_o)
    else $error("unavailable state not left");

  a_uas_inhibit: assert property (
    st_r.unavail && !wr_i |=> $stable(st_r.es) && $stable(st_r.ses))
    else $error("second counted while unavailable");

  a_tick_period: assert property (
    tick |=> !tick)
    else $error("second tick longer than a cycle");

endmodule

// ### include/perf_mon_pkg.sv
// Constants, field layouts and types of the framer performance monitor.
// Assumes a 40 MHz framer clock and a plain strobe register port.
package perf_mon_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_FCS = 8'h04;
  localparam logic [7:0] OFS_ES_THR = 8'h08;
  localparam logic [7:0] OFS_BES_THR = 8'h0C;
  localparam logic [7:0] OFS_SES_THR = 8'h10;
  localparam logic [7:0] OFS_EVT_EN = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_BPV_CNT = 8'h1C;
  localparam logic [7:0] OFS_ALIGN_CNT = 8'h20;
  localparam logic [7:0] OFS_CRC_CNT = 8'h24;
  localparam logic [7:0] OFS_EBIT_CNT = 8'h28;
  localparam logic [7:0] OFS_ES_CNT = 8'h2C;
  localparam logic [7:0] OFS_BES_CNT = 8'h30;
  localparam logic [7:0] OFS_SES_CNT = 8'h34;
  localparam logic [7:0] OFS_UAS_CNT = 8'h38;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int MODE_LC_LSB = 0;
  localparam int MODE_FM_LSB = 2;
  localparam int MODE_SD_LSB = 5;
  localparam int FCS_BIT = 2;
  localparam int EN_ALIGN_BIT = 0;
  localparam int EN_CRC_BIT = 1;
  localparam int EN_EBIT_BIT = 2;
  localparam int EN_SA6_NT_BIT = 3;
  localparam int EN_SA6_NTR_BIT = 4;
  localparam int EN_OVR_BIT = 7;
  localparam int ST_UNAVAIL_BIT = 0;
  localparam int ST_EXCRC_BIT = 1;
  localparam logic [15:0] THR_RESET = 16'h0000;
  localparam logic [7:0] EVT_EN_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LC_AMI, LC_B8ZS, LC_HDB3} line_code_t;
  typedef enum logic [2:0] {FM_SF_D4, FM_SF_SC, FM_SF_DDS, FM_ESF, FM_E1, FM_E1_CRC}
    frame_mode_t;
  typedef enum logic [1:0] {SD_LT, SD_LT_REMOTE, SD_NT, SD_NT_REMOTE} e1_side_t;

  // ----------------------------------------------------------------
  // Counts and limits
  // ----------------------------------------------------------------
  localparam int SEC_W = 14;
  localparam logic [4:0] AMI_ZERO_RUN = 5'h10;
  localparam logic [4:0] B8ZS_ZERO_SPAN = 5'h08;
  localparam logic [4:0] HDB3_ZERO_SPAN = 5'h04;
  localparam logic [SEC_W-1:0] EXC_CRC_ESF = 14'h0140;
  localparam logic [SEC_W-1:0] EXC_CRC_E1 = 14'h0393;
  localparam logic [SEC_W-1:0] SES_T1_SF = 14'h0008;
  localparam logic [SEC_W-1:0] SES_E1_PLAIN = 14'h0010;
  localparam logic [SEC_W-1:0] ES_DEFAULT = 14'h0001;
  localparam logic [SEC_W-1:0] BES_DEFAULT = 14'h0002;
  localparam logic [3:0] UAS_RUN = 4'hA;
  localparam int CLOCK_HZ = 40000000;
  localparam int SECOND_MS = 1000;
  localparam int SECOND_CYCLES = CLOCK_HZ / 1000 * SECOND_MS;

endpackage

// ### rtl/second_timer.sv
// One-second interval timer: a one-cycle tick at the end of each second.
// Assumes the framer clock is free running.
`timescale 1ns/10ps
module second_timer
  import perf_mon_pkg::*;
#(
  parameter int CYCLES = SECOND_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  output logic tick_o
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } tmr_t;

  tmr_t st_r;
  tmr_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = (st_r.cnt == LAST);
    st_nxt.cnt = st_nxt.tick ? '0 : st_r.cnt + CW'(1);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_o = st_r.tick;

endmodule

// ### test/tb_top.sv
// Self-checking testbench of the framer performance monitor.
// Assumes a shortened second (SECOND_LEN) so that whole seconds fit in the run.
`timescale 1ns/10ps
module tb_top;
  import perf_mon_pkg::*;
  localparam int SL = 1000;
  localparam logic [12:0] CRC = 13'h0400;

  // ----------------------------------------------------------------
  // Stimulus signals and design
  // ----------------------------------------------------------------
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [12:0] ev = '0;
  logic [3:0] sa6_code = 4'h0;
  logic [DATA_W-1:0] rdata_o;
  logic unavail_o;
  logic excess_crc_o;
  logic second_tick_o;
  logic [7:0] clr [5] = '{OFS_ES_CNT, OFS_BES_CNT, OFS_SES_CNT, OFS_UAS_CNT, OFS_CRC_CNT};
  logic [12:0] side_ev [4] = '{13'h0400, 13'h0800, 13'h1000, 13'h1000};
  int err_total = 0;
  int n_checks = 0;

  always #12.5 clock_i = ~clock_i;

  perf_counters #(.SECOND_LEN(SL)) i_perf_counters (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bit_valid_i(ev[0]),
    .one_pulse_i(ev[1]), .line_code_violation_i(ev[2]), .code_viol_i(ev[3]),
    .terminal_framing_bit_err_i(ev[4]), .signalling_framing_bit_err_i(ev[5]),
    .ts24_align_err_i(ev[6]), .extended_superframe_framing_bit_err_i(ev[7]),
    .fas_err_i(ev[8]), .nfas_err_i(ev[9]), .crc_err_i(ev[10]), .ebit_zero_i(ev[11]),
    .sa6_stb_i(ev[12]), .sa6_code_i(sa6_code), .unavail_o(unavail_o),
    .excess_crc_o(excess_crc_o), .second_tick_o(second_tick_o));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk(nm, exp, rdata_o);
  endtask

  task automatic burst(input logic [12:0] m, input int n);
    repeat (n) begin
      @(posedge clock_i);
      ev <= m;
    end
    @(posedge clock_i);
    ev <= '0;
  endtask

  task automatic wait_tick;
    int k;
    k = 0;
    do begin
      @(posedge clock_i);
      #1;
      k++;
    end while (second_tick_o !== 1'b1 && k < 2 * SL);
    if (k >= 2 * SL) begin
      err_total++;
      $display("MISMATCH second_tick expected 1 seen 0");
    end
  endtask

  task automatic sec(input int n);
    burst(CRC, n);
    wait_tick;
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd_chk("ses_thr", OFS_SES_THR, THR_RESET);
    rd_chk("unmapped", 8'hFC, 16'h0000);
    burst(13'h0001, 15);
    burst(13'h0003, 1);
    burst(13'h0001, 16);
    burst(13'h0003, 1);
    burst(13'h0004, 1);
    burst(13'h0008, 1);
    rd_chk("bpv_ami", OFS_BPV_CNT, 16'h0002);
    wr(OFS_MODE, {9'h000, SD_LT, FM_SF_D4, LC_B8ZS});
    wr(OFS_BPV_CNT, 16'h0000);
    burst(13'h0003, 1);
    burst(13'h0001, 16);
    burst(13'h0008, 1);
    rd_chk("bpv_b8zs", OFS_BPV_CNT, 16'h0003);
    wr(OFS_MODE, {9'h000, SD_LT, FM_E1, LC_HDB3});
    wr(OFS_BPV_CNT, 16'h0000);
    burst(13'h0003, 1);
    burst(13'h0001, 7);
    burst(13'h0003, 1);
    burst(13'h0008, 1);
    rd_chk("bpv_hdb3", OFS_BPV_CNT, 16'h0002);
    burst(13'h0100, 1);
    burst(13'h0200, 1);
    wr(OFS_FCS, 16'h0004);
    burst(13'h0200, 1);
    burst(13'h0100, 1);
    rd_chk("align_e1", OFS_ALIGN_CNT, 16'h0003);
    wr(OFS_MODE, {9'h000, SD_LT, FM_SF_D4, LC_AMI});
    burst(13'h0010, 1);
    burst(13'h0020, 1);
    wr(OFS_FCS, 16'h0000);
    wr(OFS_MODE, {9'h000, SD_LT, FM_SF_SC, LC_AMI});
    burst(13'h0020, 1);
    burst(13'h0010, 1);
    rd_chk("align_sf", OFS_ALIGN_CNT, 16'h0006);
    wr(OFS_MODE, {9'h000, SD_LT, FM_SF_DDS, LC_AMI});
    burst(13'h0040, 1);
    wr(OFS_MODE, {9'h000, SD_LT, FM_ESF, LC_AMI});
    burst(13'h0080, 1);
    rd_chk("align_dds_esf", OFS_ALIGN_CNT, 16'h0008);
    wr(OFS_MODE, {9'h000, SD_LT, FM_E1_CRC, LC_HDB3});
    burst(CRC, 3);
    burst(13'h0800, 2);
    rd_chk("crc_e1", OFS_CRC_CNT, 16'h0003);
    rd_chk("ebit", OFS_EBIT_CNT, 16'h0002);
    // Per-second judgments in ESF, counters cleared just after a boundary
    wr(OFS_MODE, {9'h000, SD_LT, FM_ESF, LC_AMI});
    wait_tick;
    foreach (clr[i]) wr(clr[i], 16'h0000);
    sec(2);
    rd_chk("es", OFS_ES_CNT, 16'h0001);
    rd_chk("bes", OFS_BES_CNT, 16'h0001);
    sec(320);
    chk("excess", 16'h0001, {15'h0000, excess_crc_o});
    rd_chk("status", OFS_STATUS, 16'h0002);
    rd_chk("ses", OFS_SES_CNT, 16'h0001);
    rd_chk("bes_320", OFS_BES_CNT, 16'h0001);
    rd_chk("crc_esf", OFS_CRC_CNT, 16'h0142);
    wr(OFS_SES_THR, 16'h0003);
    sec(3);
    rd_chk("ses_thr3", OFS_SES_CNT, 16'h0002);
    wr(OFS_ES_THR, 16'h0003);
    wr(OFS_SES_THR, 16'h000A);
    sec(2);
    rd_chk("es_thr3", OFS_ES_CNT, 16'h0003);
    rd_chk("bes_2", OFS_BES_CNT, 16'h0002);
    // Ten severe seconds enter the unavailable state, ten clean ones leave it
    wr(OFS_SES_THR, 16'h0003);
    repeat (9) sec(3);
    chk("unavail_9", 16'h0000, {15'h0000, unavail_o});
    sec(3);
    chk("unavail_10", 16'h0001, {15'h0000, unavail_o});
    rd_chk("ses_run", OFS_SES_CNT, 16'h000C);
    sec(3);
    rd_chk("es_inhib", OFS_ES_CNT, 16'h000D);
    rd_chk("ses_inhib", OFS_SES_CNT, 16'h000C);
    rd_chk("uas_1", OFS_UAS_CNT, 16'h0001);
    repeat (9) sec(0);
    chk("unavail_stay", 16'h0001, {15'h0000, unavail_o});
    sec(0);
    chk("unavail_exit", 16'h0000, {15'h0000, unavail_o});
    rd_chk("uas_11", OFS_UAS_CNT, 16'h000B);
    // Default errored condition for each E1 terminal side
    wr(OFS_ES_THR, 16'h0000);
    wr(OFS_SES_THR, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_MODE, {9'h000, s[1:0], FM_E1_CRC, LC_HDB3});
      sa6_code <= (s == 2) ? 4'h2 : 4'h1;
      burst(side_ev[s], 1);
      wait_tick;
    end
    rd_chk("es_sides", OFS_ES_CNT, 16'h0011);
    // Enable override picks the counted events; then E1 plain framing limits
    wr(OFS_EVT_EN, 16'h0084);
    rd_chk("evt_en", OFS_EVT_EN, 16'h0084);
    burst(CRC, 2);
    wait_tick;
    rd_chk("es_ovr_off", OFS_ES_CNT, 16'h0011);
    burst(13'h0800, 1);
    wait_tick;
    rd_chk("es_ovr_on", OFS_ES_CNT, 16'h0012);
    wr(OFS_EVT_EN, 16'h0000);
    wr(OFS_MODE, {9'h000, SD_LT, FM_E1, LC_HDB3});
    burst(13'h0100, 15);
    wait_tick;
    rd_chk("bes_e1", OFS_BES_CNT, 16'h0003);
    burst(13'h0100, 16);
    wait_tick;
    rd_chk("ses_e1", OFS_SES_CNT, 16'h000D);
    end_sim;
  end

  initial begin
    repeat (60000) @(posedge clock_i);
    err_total++;
    end_sim;
  end
endmodule
